/* File: logic/mt_global_pkg.sv */
// Package: offsets, field positions and reset values of the global control
package mt_global_pkg;
   // Register selects on the system register port
   localparam logic [2:0] SEL_GLOBAL_CONTROL  = 3'h1;
   localparam logic [2:0] SEL_CAPABILITY_CFG  = 3'h2;

   // Control register fields
   localparam int unsigned CTL_ENABLE_BIT    = 0;
   localparam int unsigned CTL_CONFIG_BIT    = 1;
   localparam int unsigned CTL_SHARE_BIT     = 2;
   localparam logic        CTL_ENABLE_RESET  = 1'b0;
   localparam logic        CTL_CONFIG_RESET  = 1'b0;
   localparam logic        CTL_SHARE_RESET   = 1'b0;

   // Capability register fields
   localparam int unsigned CFG_SECOND_BIT    = 31;
   localparam int unsigned CFG_CTX_PART_BIT  = 30;
   localparam int unsigned CFG_SHARABLE_BIT  = 29;
   localparam int unsigned CFG_GATING_BIT    = 28;
   localparam int unsigned CFG_VP_PART_BIT   = 27;
   localparam int unsigned CFG_POOL_LSB      = 16;
   localparam int unsigned CFG_POOL_W        = 10;
   localparam int unsigned CFG_ALLOC_BIT     = 15;
   localparam int unsigned CFG_VP_LSB        = 10;
   localparam int unsigned CFG_VP_W          = 4;
   localparam int unsigned CFG_CTX_LSB       = 0;
   localparam int unsigned CFG_CTX_W         = 8;

   // Thread context and virtual processor widths
   localparam int unsigned CTX_NUM           = 4;
   localparam int unsigned VP_NUM            = 2;
   localparam int unsigned PER_VP_FIELD_A_W        = 6;

   typedef enum logic [1:0] {
      RUN_SINGLE  = 2'b00,
      RUN_MULTI   = 2'b01,
      RUN_QUIESCE = 2'b10
   } run_mode_t;
endpackage : mt_global_pkg

/* File: logic/mt_run_if.sv */
// Interface: run-mode state passed from control to the context gate
interface mt_run_if;
   import mt_global_pkg::*;
   mt_global_pkg::run_mode_t   mode;
   logic [CTX_NUM-1:0]         owner;
   logic [CTX_NUM-1:0]         activated;
   modport ctrl (output mode, output owner, output activated);
   modport gate (input mode, input owner, input activated);
endinterface : mt_run_if

/* File: logic/mt_context_gate.sv */
// Context gate: per-context run permission from the global run mode
module mt_context_gate
   import mt_global_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                reset,
   input  wire logic                clock_enable,
   mt_run_if.gate                   run,
   output logic [CTX_NUM-1:0]       ctx_run_q
);
   // =====================================================
   // Per-context permission
   genvar g;
   generate
      for (g = 0; g < CTX_NUM; g = g + 1) begin : g_ctx
         always_ff @(posedge clock) begin
            if (reset) begin
               ctx_run_q[g] <= (g == 0);
            end else if (clock_enable) begin
               unique case (run.mode)
                  RUN_MULTI: begin
                     ctx_run_q[g] <= run.activated[g];
                  end
                  RUN_SINGLE,
                  RUN_QUIESCE: begin
                     ctx_run_q[g] <= run.owner[g];
                  end
                  default: begin
                     ctx_run_q[g] <= run.owner[g];
                  end
               endcase
            end
         end
      end
   endgenerate
endmodule : mt_context_gate

/* File: logic/mt_global_control.sv */
// Global multithread control and capability registers with run gating
module mt_global_control
   import mt_global_pkg::*;
#(
   parameter logic                  HAS_SECOND_CFG = 1'b0,
   parameter logic                  CTX_PARTITION  = 1'b0,
   parameter logic                  TLB_SHARABLE   = 1'b1,
   parameter logic                  GATING_STORAGE = 1'b0,
   parameter logic                  VP_PARTITION   = 1'b0,
   parameter logic [9:0]            POOL_PAIRS     = 10'h000,
   parameter logic                  CTX_ALLOCATE   = 1'b1,
   parameter logic [5:0]            TLB_TOTAL_M1   = 6'h1f,
   parameter logic [5:0]            TLB_SLICE_M1   = 6'h0f
)
(
   input  wire logic                         clock,
   input  wire logic                         reset,
   input  wire logic                         clock_enable,
   input  wire logic                         reg_write,
   input  wire logic                         reg_read,
   input  wire logic [2:0]                   reg_select,
   input  wire logic [31:0]                  reg_wdata,
   input  wire logic                         issuer_master,
   input  wire logic [mt_global_pkg::CTX_NUM-1:0] issuer_ctx,
   input  wire logic                         vp_enable_instruction,
   input  wire logic                         vp_disable_instruction,
   input  wire logic [mt_global_pkg::CTX_NUM-1:0] ctx_activated,
   input  wire logic [mt_global_pkg::VP_NUM-1:0]  vp_tlb_mmu,
   output logic [31:0]                       reg_rdata,
   output logic                              config_state_flag,
   output logic                              global_vp_enable,
   output logic                              tlb_sharing_control,
   output logic                              schedule_enable,
   output logic                              pool_limit_check,
   output logic [mt_global_pkg::CTX_NUM-1:0] ctx_run,
   output logic [mt_global_pkg::VP_NUM*mt_global_pkg::PER_VP_FIELD_A_W-1:0]
                                             per_vp_field_a
);
   import mt_global_pkg::*;

   // =====================================================
   // Capability word, fixed at build time
   function automatic logic [31:0] capability_word();
      logic [31:0] w;
      w = 32'h0000_0000;
      w[CFG_SECOND_BIT]   = HAS_SECOND_CFG;
      w[CFG_CTX_PART_BIT] = CTX_PARTITION;
      w[CFG_SHARABLE_BIT] = TLB_SHARABLE;
      w[CFG_GATING_BIT]   = GATING_STORAGE;
      w[CFG_VP_PART_BIT]  = VP_PARTITION;
      w[CFG_POOL_LSB +: CFG_POOL_W] = POOL_PAIRS;
      w[CFG_ALLOC_BIT]    = CTX_ALLOCATE;
      w[CFG_VP_LSB +: CFG_VP_W]   = 4'(VP_NUM - 1);
      w[CFG_CTX_LSB +: CFG_CTX_W] = 8'(CTX_NUM - 1);
      return w;
   endfunction : capability_word

   // Select decode used by writes and reads
   function automatic logic sel_is(input logic [2:0] s,
                                   input logic [2:0] want);
      return s == want;
   endfunction : sel_is

   logic        ctl_write;
   logic        enable_d;
   logic        config_d;
   logic        share_d;
   logic        ctrl_mode_multi;
   mt_run_if    run ();

   // Only the master may touch the control fields; capability writes drop
   assign ctl_write = reg_write && issuer_master &&
                      sel_is(reg_select, SEL_GLOBAL_CONTROL);

   // =====================================================
   // Control register next values
   always_comb begin
      enable_d = global_vp_enable;
      config_d = config_state_flag;
      share_d  = tlb_sharing_control;
      if (ctl_write) begin
         enable_d = reg_wdata[CTL_ENABLE_BIT];
         config_d = reg_wdata[CTL_CONFIG_BIT];
         // Old flag value, not the one being written, gates the change
         if (config_state_flag && TLB_SHARABLE) begin
            share_d = reg_wdata[CTL_SHARE_BIT];
         end
      end
      if (issuer_master && vp_enable_instruction) begin
         enable_d = 1'b1;
      end
      if (issuer_master && vp_disable_instruction) begin
         enable_d = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         global_vp_enable    <= CTL_ENABLE_RESET;
         config_state_flag   <= CTL_CONFIG_RESET;
         tlb_sharing_control <= CTL_SHARE_RESET;
      end else if (clock_enable) begin
         global_vp_enable    <= enable_d;
         config_state_flag   <= config_d;
         tlb_sharing_control <= share_d;
      end
   end

   a_disable_wins: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && issuer_master && vp_disable_instruction
      |=> !global_vp_enable)
      else $error("disable instruction did not clear enable");
   a_enable_sets: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && issuer_master && vp_enable_instruction &&
      !vp_disable_instruction |=> global_vp_enable)
      else $error("enable instruction did not set enable");
   a_config_write: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && ctl_write
      |=> config_state_flag == $past(reg_wdata[CTL_CONFIG_BIT]))
      else $error("config flag write lost");
   a_share_write: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && ctl_write && config_state_flag && TLB_SHARABLE
      |=> tlb_sharing_control == $past(reg_wdata[CTL_SHARE_BIT]))
      else $error("sharing write lost in config state");
   a_frozen_regs: assert property (
      @(posedge clock) disable iff (reset)
      !clock_enable |=> $stable(global_vp_enable) &&
      $stable(config_state_flag) && $stable(tlb_sharing_control) &&
      $stable(ctx_run) && $stable(reg_rdata))
      else $error("state moved with clock enable low");

   // =====================================================
   // Run ownership: the issuer of the write or disable instruction that clears enable keeps running
   always_ff @(posedge clock) begin
      if (reset) begin
         run.owner <= CTX_NUM'(1);
      end else if (clock_enable && global_vp_enable && !enable_d) begin
         run.owner <= issuer_ctx;
      end
   end

   a_owner_capture: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && global_vp_enable && !enable_d
      |=> run.owner == $past(issuer_ctx))
      else $error("clearing issuer not recorded as owner");

   always_ff @(posedge clock) begin
      if (reset) begin
         run.mode <= RUN_SINGLE;
      end else if (clock_enable) begin
         if (enable_d) begin
            run.mode <= RUN_MULTI;
         end else if (global_vp_enable) begin
            run.mode <= RUN_QUIESCE;
         end else begin
            run.mode <= RUN_SINGLE;
         end
      end
   end

   assign ctrl_mode_multi = (run.mode == RUN_MULTI);
   assign run.activated   = ctx_activated;

   a_mode_follow: assert property (
      @(posedge clock) disable iff (reset)
      ctrl_mode_multi == global_vp_enable)
      else $error("run mode does not follow enable");
   a_multi_run: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && ctrl_mode_multi |=> ctx_run == $past(ctx_activated))
      else $error("activated contexts not running");
   a_owner_run: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && !ctrl_mode_multi |=> ctx_run == $past(run.owner))
      else $error("context other than owner running");

   always_ff @(posedge clock) begin
      if (reset) begin
         schedule_enable <= 1'b0;
      end else if (clock_enable) begin
         schedule_enable <= enable_d;
      end
   end

   // =====================================================
   // TLB sizing, maintained by hardware only with a fixed pool
   genvar v;
   generate
      for (v = 0; v < VP_NUM; v = v + 1) begin : g_vp
         always_ff @(posedge clock) begin
            if (reset) begin
               per_vp_field_a[v*PER_VP_FIELD_A_W +: PER_VP_FIELD_A_W] <= TLB_SLICE_M1;
            end else if (clock_enable && POOL_PAIRS == 10'h000) begin
               if (share_d && vp_tlb_mmu[v]) begin
                  per_vp_field_a[v*PER_VP_FIELD_A_W +: PER_VP_FIELD_A_W]
                     <= TLB_TOTAL_M1;
               end else begin
                  // Fixed-mapping units keep their slice size
                  per_vp_field_a[v*PER_VP_FIELD_A_W +: PER_VP_FIELD_A_W]
                     <= TLB_SLICE_M1;
               end
            end
         end

         a_size_shared: assert property (
            @(posedge clock) disable iff (reset)
            clock_enable && POOL_PAIRS == 10'h000 && share_d &&
            vp_tlb_mmu[v]
            |=> per_vp_field_a[v*PER_VP_FIELD_A_W +: PER_VP_FIELD_A_W] == TLB_TOTAL_M1)
            else $error("shared unit size not the shared total");
         a_size_fixed: assert property (
            @(posedge clock) disable iff (reset)
            clock_enable && !vp_tlb_mmu[v]
            |=> per_vp_field_a[v*PER_VP_FIELD_A_W +: PER_VP_FIELD_A_W] == TLB_SLICE_M1)
            else $error("fixed-mapping unit size moved");
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (reset) begin
         pool_limit_check <= 1'b1;
      end else if (clock_enable) begin
         pool_limit_check <= !share_d;
      end
   end

   a_pool_follow: assert property (
      @(posedge clock) disable iff (reset)
      pool_limit_check == !tlb_sharing_control)
      else $error("pool limit does not track sharing");

   // =====================================================
   // Read port, registered
   always_ff @(posedge clock) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
      end else if (clock_enable && reg_read) begin
         if (sel_is(reg_select, SEL_GLOBAL_CONTROL)) begin
            reg_rdata <= {29'h0000_0000, tlb_sharing_control,
                          config_state_flag, global_vp_enable};
         end else if (sel_is(reg_select, SEL_CAPABILITY_CFG)) begin
            reg_rdata <= capability_word();
         end else begin
            reg_rdata <= 32'h0000_0000;
         end
      end
   end

   a_ctl_read: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && reg_read && reg_select == SEL_GLOBAL_CONTROL
      |=> reg_rdata[31:3] == 29'h0000_0000 &&
          reg_rdata[0] == $past(global_vp_enable))
      else $error("control read wrong");

   mt_context_gate u_gate (
      .clock        (clock),
      .reset        (reset),
      .clock_enable (clock_enable),
      .run          (run.gate),
      .ctx_run_q    (ctx_run)
   );

   // =====================================================
   // Checks
   a_nonmaster_frozen: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && !issuer_master |=> $stable(global_vp_enable))
      else $error("enable changed without master");
   a_config_master: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && !issuer_master |=> $stable(config_state_flag))
      else $error("config flag changed without master");
   a_share_gate: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && !config_state_flag |=> $stable(tlb_sharing_control))
      else $error("sharing changed outside config state");
   a_no_schedule: assert property (
      @(posedge clock) disable iff (reset)
      !global_vp_enable |-> !schedule_enable)
      else $error("scheduling while disabled");
   a_single_run: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && !global_vp_enable ##1 clock_enable && !global_vp_enable
      |=> $onehot0(ctx_run))
      else $error("more than one context with enable off");
   a_limit_off: assert property (
      @(posedge clock) disable iff (reset)
      tlb_sharing_control && $past(clock_enable) |-> !pool_limit_check)
      else $error("pool limit enforced while sharing");
   a_cap_read: assert property (
      @(posedge clock) disable iff (reset)
      clock_enable && reg_read && reg_select == SEL_CAPABILITY_CFG
      |=> reg_rdata[26] == 1'b0 && reg_rdata[14] == 1'b0 &&
          reg_rdata[9:8] == 2'b00 && reg_rdata[7:0] == 8'(CTX_NUM - 1))
      else $error("capability read wrong");
   a_reset_ctx0: assert property (
      @(posedge clock)
      reset |=> ctx_run == CTX_NUM'(1))
      else $error("context 0 not alone after reset");
endmodule : mt_global_control

/* File: verification/mt_global_control_tb_top.sv */
// Testbench: global multithread control and capability registers
module mt_global_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mt_global_pkg::*;
   // ==========================================================
   // Signals and reference state
   localparam logic [5:0]  TOT = 6'h1f;
   localparam logic [5:0]  SLC = 6'h0f;
   localparam logic [31:0] CAP = {5'b11101, 1'b0, 10'h000, 1'b1, 1'b0,
      4'(VP_NUM - 1), 2'b00, 8'(CTX_NUM - 1)};
   logic        clock, reset, clock_enable, reg_write, reg_read;
   logic        issuer_master, vp_enable_instruction, vp_disable_instruction;
   logic [2:0]  reg_select;
   logic [31:0] reg_wdata, reg_rdata, rd_m;
   logic [3:0]  issuer_ctx, ctx_activated, ctx_run, own_m;
   logic [1:0]  vp_tlb_mmu;
   logic [11:0] per_vp_field_a;
   logic        config_state_flag, global_vp_enable, tlb_sharing_control;
   logic        schedule_enable, pool_limit_check, en_m, cfg_m, sh_m, nx;
   int          seed = 28;
   int          miscompares = 0;
   int          n_compared = 0;

   // Sharable, no gating, fixed pool, allocatable contexts: the defaults
   mt_global_control #(.HAS_SECOND_CFG(1'b1), .CTX_PARTITION(1'b1),
      .VP_PARTITION(1'b1), .TLB_TOTAL_M1(TOT),
      .TLB_SLICE_M1(SLC)) u_dut (.clock(clock), .reset(reset),
      .clock_enable(clock_enable), .reg_write(reg_write),
      .reg_read(reg_read), .reg_select(reg_select), .reg_wdata(reg_wdata),
      .issuer_master(issuer_master), .issuer_ctx(issuer_ctx),
      .vp_enable_instruction(vp_enable_instruction),
      .vp_disable_instruction(vp_disable_instruction),
      .ctx_activated(ctx_activated), .vp_tlb_mmu(vp_tlb_mmu),
      .reg_rdata(reg_rdata), .config_state_flag(config_state_flag),
      .global_vp_enable(global_vp_enable),
      .tlb_sharing_control(tlb_sharing_control),
      .schedule_enable(schedule_enable), .pool_limit_check(pool_limit_check),
      .ctx_run(ctx_run), .per_vp_field_a(per_vp_field_a));

   always #20 clock = ~clock;

   // ==========================================================
   // Comparison and operation tasks
   task automatic chk(input logic [31:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t ns: %s got %h expected %h",
            $time, what, got, exp);
      end
   endtask : chk

   function automatic logic [5:0] fld(input int i);
      return (sh_m && vp_tlb_mmu[i]) ? TOT : SLC;
   endfunction : fld

   task automatic check_outs;
      chk(global_vp_enable, en_m, "enable");
      chk(config_state_flag, cfg_m, "config");
      chk(tlb_sharing_control, sh_m, "share");
      chk(schedule_enable, en_m, "schedule");
      chk(pool_limit_check, !sh_m, "pool limit");
      chk(per_vp_field_a, {fld(1), fld(0)}, "per_vp_field_a");
      chk(reg_rdata, rd_m, "read data");
   endtask : check_outs

   // Drives one request, then checks registers and the lagging run mask
   task automatic op(input logic w, r, input logic [2:0] s,
      input logic [31:0] d, input logic m, ei, di, ce);
      @(negedge clock);
      ctx_activated = 4'($random(seed));
      issuer_ctx = 4'h1 << ($unsigned($random(seed)) % 4);
      {reg_write, reg_read, reg_select, reg_wdata} = {w, r, s, d};
      {issuer_master, vp_enable_instruction} = {m, ei};
      {vp_disable_instruction, clock_enable} = {di, ce};
      if (ce) begin
         if (r) rd_m = (s == SEL_GLOBAL_CONTROL) ?
            {29'h0, sh_m, cfg_m, en_m} : (s == SEL_CAPABILITY_CFG) ?
            CAP : 32'h0;
         nx = en_m;
         if (m && w && s == SEL_GLOBAL_CONTROL) begin
            if (cfg_m) sh_m = d[2];
            cfg_m = d[1];
            nx = d[0];
         end
         if (m && ei) nx = 1'b1;
         if (m && di) nx = 1'b0;
         if (en_m && !nx) own_m = issuer_ctx;
         en_m = nx;
      end
      @(negedge clock);
      {reg_write, reg_read, vp_enable_instruction} = 3'b000;
      {vp_disable_instruction, clock_enable} = 2'b01;
      check_outs();
      @(negedge clock);
      // Run mask is only trusted one edge later, as after a barrier
      chk(ctx_run, en_m ? ctx_activated : own_m, "run");
   endtask : op

   task automatic do_reset;
      @(negedge clock);
      reset = 1'b1;
      repeat (4) @(negedge clock);
      reset = 1'b0;
      {en_m, cfg_m, sh_m, own_m, rd_m} = {3'b000, 4'h1, 32'h0};
      check_outs();
      chk(ctx_run, 4'h1, "run after reset");
   endtask : do_reset

   task automatic close_out;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out

   // ==========================================================
   // Scenarios
   initial begin
      {clock, reset, clock_enable, reg_write, reg_read} = 5'b11100;
      {issuer_master, vp_enable_instruction, vp_disable_instruction} = 3'b0;
      {reg_select, reg_wdata, issuer_ctx, ctx_activated} = '0;
      vp_tlb_mmu = 2'b11;
      do_reset();
      op(0, 1, SEL_CAPABILITY_CFG, 0, 1, 0, 0, 1);
      op(1, 0, SEL_CAPABILITY_CFG, $random(seed), 1, 0, 0, 1);
      op(0, 1, SEL_CAPABILITY_CFG, 0, 1, 0, 0, 1);
      for (int s = 0; s < 8; s++)
         if (s != 1 && s != 2) op(0, 1, 3'(s), 0, 1, 0, 0, 1);
      $display("test capability finished");
      // Software never sets config state and enable together
      op(1, 0, SEL_GLOBAL_CONTROL, 32'h1, 0, 0, 0, 1);
      op(1, 0, SEL_GLOBAL_CONTROL, 32'h2, 0, 0, 0, 1);
      vp_tlb_mmu = 2'b01;
      op(1, 0, SEL_GLOBAL_CONTROL, 32'h2, 1, 0, 0, 1);
      op(1, 0, SEL_GLOBAL_CONTROL, 32'h6, 1, 0, 0, 1);
      // No mapped access follows a sharing change in this bench
      op(0, 1, SEL_GLOBAL_CONTROL, 0, 1, 0, 0, 1);
      op(1, 0, SEL_GLOBAL_CONTROL, 32'h0, 1, 0, 0, 1);
      op(1, 0, SEL_GLOBAL_CONTROL, 32'h4, 1, 0, 0, 1);
      $display("test config and sharing finished");
      vp_tlb_mmu = 2'b11;
      op(0, 0, 0, 0, 1, 1, 0, 1);
      op(0, 0, 0, 0, 0, 0, 1, 1);
      op(0, 1, SEL_GLOBAL_CONTROL, 0, 1, 1, 1, 1);
      op(1, 0, SEL_GLOBAL_CONTROL, 32'h1, 1, 0, 0, 1);
      op(1, 0, SEL_GLOBAL_CONTROL, 32'h0, 1, 0, 0, 1);
      op(0, 0, 0, 0, 1, 1, 0, 0);
      for (int i = 0; i < 16; i++) begin
         int k;
         k = $unsigned($random(seed)) % 3;
         op(k == 2, 0, SEL_GLOBAL_CONTROL, 32'($random(seed)) & 32'h1,
            1'($random(seed)), k == 0, k == 1, 1);
      end
      $display("test enable and disable finished");
      op(0, 0, 0, 0, 1, 1, 0, 1);
      do_reset();
      $display("test mid-run reset finished");
      close_out();
   end

   initial begin
      repeat (3000) @(posedge clock);
      miscompares++;
      $display("unexpected at %0t ns: watchdog expired", $time);
      close_out();
   end
endmodule : mt_global_control_tb_top
